// ---- src/sync_rx_pkg.sv ----
/*
 * Constants and types shared by both ends of the clock-synchronous serial receive link.
 * Assumes a single 25 MHz system clock with a synchronous active-high reset at each end.
 */
//
// Overview of operation
// - Ready only after dummy write and both enables
// - Receive-ready output goes low when ready
// - Transmitter clocks only after ready seen low
// - First active edge fills the top bit, or the bottom bit when MSB first
// - Later edges shift right, or left when MSB first, take new bit
// - Full byte copied into receive buffer
// - Transfer clock rests high after byte
// - Completion sets complete flag and interrupt request
// - Low-byte buffer read clears complete flag
// - Interrupt request cleared by accept or software
// - Clock source: divide by 1, 8, 32, or pin
// - Polarity selects rising or falling pin sampling edge; internal clock always samples rising
// - Multi-pin clock output forces ready function off
// - Transmitter holds clock idle before reception starts
// - Ready high at start, low at completion
// - Overrun sets error, overwrites buffer, keeps request
package sync_rx_pkg;

	localparam int unsigned BYTE_BITS    = 8;
	localparam int unsigned DIV8_COUNT   = 8;
	localparam int unsigned DIV32_COUNT  = 32;
	localparam logic [7:0]  BUFFER_RESET = 8'h00;

	// Transfer clock source selection.
	typedef enum logic [1:0] {
		CLK_SRC_DIV1,
		CLK_SRC_DIV8,
		CLK_SRC_DIV32,
		CLK_SRC_PIN
	} clk_src_t;

	// Transmitter-side half period of the generated link clock, in system cycles.
	localparam int unsigned TX_HALF_PERIOD = 4;

endpackage : sync_rx_pkg

// ---- src/sync_rx_link_if.sv ----
/*
 * Interface joining the receiving device and the external transmitter.
 * Assumes both ends run on the same system clock; pins are plain one-way wires.
 */
`timescale 1ns/1ps
interface sync_rx_link_if;
	logic transfer_clock_pin;
	logic serial_data_in;
	logic receive_ready_out;

	modport device_mp
	(
		input  transfer_clock_pin,
		input  serial_data_in,
		output receive_ready_out
	);

	modport transmitter_mp
	(
		output transfer_clock_pin,
		output serial_data_in,
		input  receive_ready_out
	);
endinterface : sync_rx_link_if

// ---- src/sync_serial_receiver.sv ----
/*
 * Receive path of a clock-synchronous serial unit: shift register, receive buffer,
 * complete, overrun and interrupt-request flags, ready output and clock selection.
 * Assumes the transmitter honours the ready output and parks the clock idle between bytes.
 */
`timescale 1ns/1ps
module sync_serial_receiver
	import sync_rx_pkg::*;
(
	input  wire logic           i_clk,
	input  wire logic           i_srst,
	sync_rx_link_if.device_mp   link,
	input  wire logic           i_receive_enable_bit,
	input  wire logic           i_transmit_enable_bit,
	input  wire logic           i_dummy_write,
	input  wire clk_src_t       i_clk_src,
	input  wire logic           i_clk_polarity,
	input  wire logic           i_msb_first,
	input  wire logic           i_multi_pin_clk,
	input  wire logic           i_ready_disable,
	input  wire logic           i_buffer_low_read,
	input  wire logic           i_irq_accept,
	input  wire logic           i_irq_sw_clear,
	output logic [7:0]          o_receive_buffer,
	output logic                o_receive_complete_flag,
	output logic                o_overrun_flag,
	output logic                o_receive_irq_request,
	output logic                o_transmit_buffer_empty_flag,
	output logic                o_int_clk_out
);

	// ==========================================================
	// Internal clock taps
	logic [4:0] div_r;
	logic [4:0] div_nxt;
	logic       tap_pulse;

	always_comb
	begin
		div_nxt = div_r + 5'h01;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			div_r <= 5'h00;
		else
			div_r <= div_nxt;
	end

	always_comb
	begin
		unique case (i_clk_src)
			CLK_SRC_DIV1:  tap_pulse = 1'b1;
			CLK_SRC_DIV8:  tap_pulse = (div_r[2:0] == 3'(DIV8_COUNT - 1));
			CLK_SRC_DIV32: tap_pulse = (div_r == 5'(DIV32_COUNT - 1));
			CLK_SRC_PIN:   tap_pulse = 1'b0;
		endcase
	end

	// ==========================================================
	// Pin synchroniser and edge detection
	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic int_clk_r;
	logic int_clk_nxt;
	logic busy_r;
	logic busy_nxt;
	logic ext_sel;
	logic clk_now;
	logic clk_prev;
	logic sample_edge;

	assign ext_sel = (i_clk_src == CLK_SRC_PIN);

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			sync3_r <= 1'b1;
		end
		else
		begin
			sync1_r <= link.transfer_clock_pin;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// Internal clock toggles on each tap while a byte is in progress and rests high otherwise.
	always_comb
	begin
		int_clk_nxt = int_clk_r;
		if (!busy_r || ext_sel)
			int_clk_nxt = 1'b1;
		else if (tap_pulse)
			int_clk_nxt = ~int_clk_r;
	end

	always_comb
	begin
		clk_now     = ext_sel ? sync2_r : int_clk_r;
		clk_prev    = ext_sel ? sync3_r : int_clk_nxt;
		sample_edge = ext_sel ? (i_clk_polarity ? (clk_prev && !clk_now) : (!clk_prev && clk_now))
			: (!int_clk_r && int_clk_nxt);
	end

	// ==========================================================
	// Receive sequencing
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READY,
		ST_SHIFT
	} rx_state_t;

	rx_state_t  state_r;
	rx_state_t  state_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [3:0] count_r;
	logic [3:0] count_nxt;
	logic [7:0] buf_r;
	logic [7:0] buf_nxt;
	logic       done_r;
	logic       done_nxt;
	logic       ovr_r;
	logic       ovr_nxt;
	logic       irq_r;
	logic       irq_nxt;
	logic       tbe_r;
	logic       tbe_nxt;
	logic       rts_r;
	logic       rts_nxt;
	logic       byte_done;

	always_comb
	begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		count_nxt = count_r;
		buf_nxt   = buf_r;
		done_nxt  = done_r;
		ovr_nxt   = ovr_r;
		irq_nxt   = irq_r;
		tbe_nxt   = tbe_r;
		rts_nxt   = rts_r;
		busy_nxt  = busy_r;
		byte_done = 1'b0;
		if (i_dummy_write)
			tbe_nxt = 1'b0;
		if (i_buffer_low_read)
			done_nxt = 1'b0;
		if (i_irq_accept || i_irq_sw_clear)
			irq_nxt = 1'b0;
		if (!i_receive_enable_bit)
		begin
			state_nxt = ST_IDLE;
			rts_nxt   = 1'b1;
			busy_nxt  = 1'b0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					if (i_transmit_enable_bit && !tbe_r)
					begin
						state_nxt = ST_READY;
						rts_nxt   = 1'b0;
						busy_nxt  = 1'b1;
						tbe_nxt   = 1'b1;
						count_nxt = 4'h0;
					end
				end
				ST_READY, ST_SHIFT:
				begin
					if (sample_edge)
					begin
						if (i_msb_first)
							shift_nxt = {shift_r[6:0], link.serial_data_in};
						else
							shift_nxt = {link.serial_data_in, shift_r[7:1]};
						count_nxt = count_r + 4'h1;
						state_nxt = ST_SHIFT;
						rts_nxt   = 1'b1;
						if (count_r == 4'(BYTE_BITS - 1))
						begin
							byte_done = 1'b1;
							state_nxt = ST_IDLE;
							busy_nxt  = 1'b0;
							rts_nxt   = 1'b0;
							buf_nxt   = i_msb_first ? {shift_r[6:0], link.serial_data_in}
								: {link.serial_data_in, shift_r[7:1]};
							if (done_r && !i_buffer_low_read)
								ovr_nxt = 1'b1;
							else
							begin
								done_nxt = 1'b1;
								irq_nxt  = 1'b1;
							end
						end
					end
				end
				default:
					state_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			state_r   <= ST_IDLE;
			shift_r   <= BUFFER_RESET;
			count_r   <= 4'h0;
			buf_r     <= BUFFER_RESET;
			done_r    <= 1'b0;
			ovr_r     <= 1'b0;
			irq_r     <= 1'b0;
			tbe_r     <= 1'b1;
			rts_r     <= 1'b1;
			busy_r    <= 1'b0;
			int_clk_r <= 1'b1;
		end
		else
		begin
			state_r   <= state_nxt;
			shift_r   <= shift_nxt;
			count_r   <= count_nxt;
			buf_r     <= buf_nxt;
			done_r    <= done_nxt;
			ovr_r     <= ovr_nxt;
			irq_r     <= irq_nxt;
			tbe_r     <= tbe_nxt;
			rts_r     <= rts_nxt;
			busy_r    <= busy_nxt;
			int_clk_r <= int_clk_nxt;
		end
	end

	assign link.receive_ready_out       = rts_r | i_ready_disable | i_multi_pin_clk;
	assign o_receive_buffer             = buf_r;
	assign o_receive_complete_flag      = done_r;
	assign o_overrun_flag               = ovr_r;
	assign o_receive_irq_request        = irq_r;
	assign o_transmit_buffer_empty_flag = tbe_r;
	// Multi-pin clock output only makes sense from the internal source.
	assign o_int_clk_out                = int_clk_r | ext_sel;

endmodule : sync_serial_receiver

// ---- src/sync_serial_transmitter.sv ----
/*
 * External transmitter end: waits for the ready output low, then clocks out one byte,
 * LSB first, changing data on the falling edge, and parks the clock high.
 * Assumes the receiver samples on the rising edge with its pin source selected.
 */
`timescale 1ns/1ps
module sync_serial_transmitter
	import sync_rx_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_srst,
	sync_rx_link_if.transmitter_mp link,
	input  wire logic              i_send_valid,
	input  wire logic [7:0]        i_send_data,
	output logic                   o_send_ready
);

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_WAIT,
		TX_LOW,
		TX_HIGH
	} tx_state_t;

	tx_state_t  state_r;
	tx_state_t  state_nxt;
	logic [7:0] data_r;
	logic [7:0] data_nxt;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	logic [2:0] tick_r;
	logic [2:0] tick_nxt;
	logic       clk_r;
	logic       clk_nxt;
	logic       sd_r;
	logic       sd_nxt;
	logic       half_done;

	assign half_done = (tick_r == 3'(TX_HALF_PERIOD - 1));

	always_comb
	begin
		state_nxt = state_r;
		data_nxt  = data_r;
		bit_nxt   = bit_r;
		tick_nxt  = half_done ? 3'h0 : tick_r + 3'h1;
		clk_nxt   = clk_r;
		sd_nxt    = sd_r;
		unique case (state_r)
			TX_IDLE:
			begin
				clk_nxt = 1'b1;
				if (i_send_valid)
				begin
					data_nxt  = i_send_data;
					bit_nxt   = 4'h0;
					state_nxt = TX_WAIT;
				end
			end
			TX_WAIT:
			begin
				if (!link.receive_ready_out && half_done)
				begin
					clk_nxt   = 1'b0;
					sd_nxt    = data_r[0];
					state_nxt = TX_LOW;
				end
			end
			TX_LOW:
			begin
				if (half_done)
				begin
					clk_nxt   = 1'b1;
					bit_nxt   = bit_r + 4'h1;
					state_nxt = TX_HIGH;
				end
			end
			TX_HIGH:
			begin
				if (half_done)
				begin
					if (bit_r == 4'(BYTE_BITS))
						state_nxt = TX_IDLE;
					else
					begin
						clk_nxt   = 1'b0;
						data_nxt  = {1'b0, data_r[7:1]};
						sd_nxt    = data_r[1];
						state_nxt = TX_LOW;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			state_r <= TX_IDLE;
			data_r  <= BUFFER_RESET;
			bit_r   <= 4'h0;
			tick_r  <= 3'h0;
			clk_r   <= 1'b1;
			sd_r    <= 1'b1;
		end
		else
		begin
			state_r <= state_nxt;
			data_r  <= data_nxt;
			bit_r   <= bit_nxt;
			tick_r  <= tick_nxt;
			clk_r   <= clk_nxt;
			sd_r    <= sd_nxt;
		end
	end

	assign link.transfer_clock_pin = clk_r;
	assign link.serial_data_in     = sd_r;
	assign o_send_ready            = (state_r == TX_IDLE);

endmodule : sync_serial_transmitter

// ---- verification/sync_rx_link_properties.sv ----
/* Checker for the receive link wires and the receiver flags.
   Assumes one clock domain; the bench connects every input by name. */
`timescale 1ns/1ps
module sync_rx_link_properties
	import sync_rx_pkg::*;
(
	input wire logic     i_clk,
	input wire logic     i_srst,
	input wire logic     transfer_clock_pin,
	input wire logic     receive_ready_out,
	input wire clk_src_t i_clk_src,
	input wire logic     i_clk_polarity,
	input wire logic     i_buffer_low_read,
	input wire logic     i_irq_accept,
	input wire logic     i_irq_sw_clear,
	input wire logic     o_receive_complete_flag,
	input wire logic     o_overrun_flag,
	input wire logic     o_receive_irq_request
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// ==========================================
	// Pin edge count
	// Counts sampling pin edges since ready last fell, so a byte over the pin must end on exactly eight.
	logic [3:0] edges_r;
	logic       pin_r;
	logic       rdy_r;
	always_ff @(posedge i_clk)
	begin
		pin_r <= transfer_clock_pin;
		rdy_r <= receive_ready_out;
		if (i_srst || (rdy_r && !receive_ready_out))
			edges_r <= 4'h0;
		else if (i_clk_polarity ? (pin_r && !transfer_clock_pin) : (!pin_r && transfer_clock_pin))
			edges_r <= edges_r + 4'h1;
	end
	// ==========================================
	// Assertions
	AST_IDLE_HIGH: assert property ($fell(receive_ready_out) && !i_clk_polarity
		|-> transfer_clock_pin)
		else $error("clock pin low when ready fell");
	AST_REST_HIGH: assert property ($rose(o_receive_complete_flag) |-> ##2 transfer_clock_pin)
		else $error("clock pin not at rest after byte");
	AST_SET_IRQ: assert property ($rose(o_receive_complete_flag) |-> o_receive_irq_request)
		else $error("request not set with complete flag");
	AST_READY_DONE: assert property ($rose(o_receive_complete_flag) &&
		i_clk_src == CLK_SRC_PIN |-> ##[0:3] !receive_ready_out)
		else $error("ready not low after byte");
	AST_OVERRUN: assert property ($rose(o_overrun_flag) |->
		o_receive_complete_flag && $stable(o_receive_irq_request))
		else $error("overrun with wrong flags");
	AST_READ_CLEARS: assert property ($fell(o_receive_complete_flag) |-> $past(i_buffer_low_read))
		else $error("complete flag fell without read");
	AST_IRQ_CLEAR: assert property ($fell(o_receive_irq_request) |->
		$past(i_irq_accept) || $past(i_irq_sw_clear))
		else $error("request fell without clear");
	AST_BYTE_EDGES: assert property ($fell(receive_ready_out) |->
		edges_r == 4'h0 || edges_r == 4'h8)
		else $error("byte ended on wrong edge count");
	cover property ($rose(o_receive_complete_flag));
	cover property ($rose(o_overrun_flag));
	cover property ($fell(o_receive_irq_request));
endmodule : sync_rx_link_properties

// ---- verification/sync_serial_receiver_bench.sv ----
/* Self-checking bench: receiver and transmitter joined by the link interface.
   Assumes the package, interface, both ends and the checker are compiled first. */
`timescale 1ns/1ps
module sync_serial_receiver_bench;
	import sync_rx_pkg::*;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       re = 1'b0;
	logic       te = 1'b0;
	logic       dw = 1'b0;
	logic       msb = 1'b0;
	logic       dis = 1'b0;
	logic       sv = 1'b0;
	logic       pol = 1'b0;
	logic       mpc = 1'b0;
	logic [2:0] pls = 3'h0;
	logic [7:0] sd = 8'h00;
	clk_src_t   src = CLK_SRC_PIN;
	logic [7:0] rbuf;
	logic       cf, ovf, irq, tbe, iclk, srdy;
	int         miscompares = 0;
	int         n_tests = 0;
	sync_rx_link_if link ();
	always #20 clk = ~clk;
	// ==========================================
	// Design and checker
	sync_serial_receiver sync_serial_receiver_i (.i_clk(clk), .i_srst(srst),
		.link(link.device_mp), .i_receive_enable_bit(re), .i_transmit_enable_bit(te),
		.i_dummy_write(dw), .i_clk_src(src), .i_clk_polarity(pol), .i_msb_first(msb),
		.i_multi_pin_clk(mpc), .i_ready_disable(dis), .i_buffer_low_read(pls[0]),
		.i_irq_accept(pls[1]), .i_irq_sw_clear(pls[2]), .o_receive_buffer(rbuf),
		.o_receive_complete_flag(cf), .o_overrun_flag(ovf), .o_receive_irq_request(irq),
		.o_transmit_buffer_empty_flag(tbe), .o_int_clk_out(iclk));
	sync_serial_transmitter sync_serial_transmitter_i (.i_clk(clk), .i_srst(srst),
		.link(link.transmitter_mp), .i_send_valid(sv), .i_send_data(sd), .o_send_ready(srdy));
	sync_rx_link_properties sync_rx_link_properties_i (.i_clk(clk), .i_srst(srst),
		.transfer_clock_pin(link.transfer_clock_pin), .receive_ready_out(link.receive_ready_out),
		.i_clk_src(src), .i_clk_polarity(pol), .i_buffer_low_read(pls[0]), .i_irq_accept(pls[1]),
		.i_irq_sw_clear(pls[2]), .o_receive_complete_flag(cf), .o_overrun_flag(ovf),
		.o_receive_irq_request(irq));
	// ==========================================
	// Helpers
	// Inputs always change 1 ns after the edge so no sampling race is possible.
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic pulse(input logic [2:0] p);
		pls = p;
		step(1);
		pls = 3'h0;
		step(1);
	endtask : pulse
	task automatic dummy;
		dw = 1'b1;
		step(1);
		dw = 1'b0;
	endtask : dummy
	// One byte over the pin, then room for the two-flop sync and buffer update.
	task automatic rx(input logic [7:0] d);
		int k;
		dummy();
		sv = 1'b1;
		sd = d;
		step(1);
		sv = 1'b0;
		for (k = 0; k < 400 && srdy !== 1'b1; k++)
			step(1);
		chk({6'h00, srdy, link.transfer_clock_pin}, 8'h03);
		step(6);
	endtask : rx
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	// ==========================================
	// Scenarios
	task automatic t_enable;
		chk({1'b0, tbe, link.receive_ready_out, rbuf[1:0], cf, ovf, irq}, 8'h60);
		re = 1'b1;
		dis = 1'b1;
		dummy();
		step(3);
		chk({6'h00, tbe, link.receive_ready_out}, 8'h01);
		te = 1'b1;
		step(3);
		chk({6'h00, tbe, link.receive_ready_out}, 8'h03);
		dis = 1'b0;
		step(3);
		chk({7'h00, link.receive_ready_out}, 8'h00);
		mpc = 1'b1;
		step(1);
		chk({7'h00, link.receive_ready_out}, 8'h01);
		mpc = 1'b0;
		step(1);
		chk({7'h00, link.receive_ready_out}, 8'h00);
	endtask : t_enable
	task automatic t_pin_bytes;
		rx(8'hA5);
		chk(rbuf, 8'hA5);
		chk({5'h00, cf, irq, link.receive_ready_out}, 8'h06);
		pulse(3'h1);
		chk({6'h00, cf, irq}, 8'h01);
		pulse(3'h2);
		chk({7'h00, irq}, 8'h00);
		rx(8'h3C);
		chk(rbuf, 8'h3C);
		pulse(3'h4);
		chk({7'h00, irq}, 8'h00);
		rx(8'h81);
		chk({cf, ovf, irq, 5'h00}, 8'hC0);
		chk(rbuf, 8'h81);
		pulse(3'h1);
		msb = 1'b1;
		rx(8'h12);
		chk(rbuf, 8'h48);
		msb = 1'b0;
	endtask : t_pin_bytes
	// Falling-edge sampling completes while the pin is still low, which rising-edge sampling
	// cannot do, so this byte tells the two polarities apart.
	task automatic t_polarity;
		int k;
		pulse(3'h1);
		pol = 1'b1;
		dummy();
		sv = 1'b1;
		sd = 8'hC3;
		step(1);
		sv = 1'b0;
		for (k = 0; k < 400 && cf !== 1'b1; k++)
			step(1);
		chk({6'h00, cf, link.transfer_clock_pin}, 8'h02);
		for (k = 0; k < 400 && srdy !== 1'b1; k++)
			step(1);
		step(6);
		chk(rbuf, 8'hC3);
		pol = 1'b0;
	endtask : t_polarity
	// Each tap gives a byte time inside the window set by the free-running divider phase.
	// Receive enable is dropped first so every byte starts from a parked internal clock.
	task automatic t_internal;
		int n [3];
		int d [3] = '{1, DIV8_COUNT, DIV32_COUNT};
		int k;
		logic in_win;
		clk_src_t s [3] = '{CLK_SRC_DIV1, CLK_SRC_DIV8, CLK_SRC_DIV32};
		for (int i = 0; i < 3; i++)
		begin
			re = 1'b0;
			pulse(3'h1);
			src = s[i];
			re = 1'b1;
			dummy();
			for (k = 0; k < 3000 && cf !== 1'b1; k++)
				step(1);
			n[i] = k;
			in_win = (n[i] >= (2 * BYTE_BITS - 1) * d[i] + 2) && (n[i] <= 2 * BYTE_BITS * d[i] + 1);
			chk({7'h00, in_win}, 8'h01);
			step(2);
			chk({6'h00, cf, iclk}, 8'h03);
		end
		chk({6'h00, n[1] > n[0], n[2] > n[1]}, 8'h03);
	endtask : t_internal
	initial
	begin
		step(10);
		srst = 1'b0;
		step(1);
		t_enable();
		t_pin_bytes();
		t_polarity();
		t_internal();
		give_verdict();
	end
	initial
	begin
		#(40 * 20000);
		miscompares++;
		give_verdict();
	end
endmodule : sync_serial_receiver_bench
